// File: core/smcg_sleep_ctrl.sv
// sleep-mode and per-module clock-gating controller with APB registers
//
// What this block does
// - sleep entered only when arm bit set and sleep instruction executes.
// - kind 00 enters idle; cpu and flash clocks stop, others run, pll only when it is source.
// - idle keeps peripherals running; any external or internal interrupt wakes.
// - kind 01 enters noise reduction; io, fast, cpu, flash clocks stop.
// - noise reduction wakes on converter, resets, program-ready, level irq zero, pin change.
// - enabled converter starts a conversion on entering idle or noise reduction.
// - kind 10 enters power-down; oscillator and all generated clocks stop.
// - power-down wakes on resets, level irq zero or pin change only.
// - kind 11 with crystal selected is standby: power-down with oscillator running.
// - standby wake start-up takes six clock cycles; restore and halt follow before the core resumes.
// - external irq line zero wakes deep modes only when level-triggered; irq one never does.
// - pll domain runs in idle and noise reduction only when pll is source.
// - interrupt wake halts core four cycles beyond start-up, then resumes.
// - register file and sram contents kept across sleep.
// - reset during sleep wakes core to the reset vector.
// - module stop bit freezes its clock and blocks its register access.
// - clearing a stop bit restarts the module in its previous state.
// - module clock stop acts in active and idle modes.
// - arm bit 5, kind field bits 4:3 of core control, reset zero.
// - stop bits timer one 3, timer zero 2, serial 1, converter 0.
`timescale 1ns/10ps
`include "smcg_defines.svh"

module smcg_sleep_ctrl #(
   parameter int STARTUP_CYC = `SMCG_DEF_STARTUP_CYC
) (
   // clock and reset
   input  wire logic                  I_CLOCK,
   input  wire logic                  I_RST,
   // apb slave
   input  wire logic                  I_PSEL,
   input  wire logic                  I_PENABLE,
   input  wire logic                  I_PWRITE,
   input  wire logic [11:0]           I_PADDR,
   input  wire logic [31:0]           I_PWDATA,
   output logic                       O_PREADY,
   output logic      [31:0]           O_PRDATA,
   output logic                       O_PSLVERR,
   // core side
   input  wire logic                  I_SLEEP_EXEC,
   input  wire logic                  I_CONV_ENABLED,
   input  wire smcg_pkg::smcg_wake_t  I_WAKE,
   input  wire logic                  I_IRQ_ENABLED,
   // peripheral register access requests
   input  wire logic [3:0]            I_MOD_ACCESS,
   // clock enables and core controls
   output smcg_pkg::smcg_clk_en_t     O_CLK_EN,
   output logic      [3:0]            O_MOD_CLK_EN,
   output logic      [3:0]            O_MOD_ACCESS_OK,
   output logic                       O_CONV_START,
   output logic                       O_RESET_VECTOR,
   output logic                       O_IRQ_RESUME,
   output logic                       O_SLEEPING
);

   localparam int CNT_W = 16;

   logic [7:0]              core_ctrl_reg;
   logic [3:0]              clk_stop_reg;
   logic [1:0]              clk_src_reg;
   smcg_pkg::smcg_state_t   state_reg;
   smcg_pkg::smcg_state_t   state_next;
   smcg_pkg::smcg_kind_t    kind_reg;
   logic                    wake_by_reset_reg;
   logic [CNT_W-1:0]        cnt_reg;
   logic [CNT_W-1:0]        cnt_next;
   logic [31:0]             rdata_next;
   logic                    wake_hit;
   logic                    reset_hit;
   logic                    arm_ok;
   logic                    standby_ok;
   smcg_pkg::smcg_kind_t    kind_sel;
   smcg_pkg::smcg_clk_en_t  clk_en_next;
   logic                    apb_wr;
   logic                    apb_rd;

   assign apb_wr    = I_PSEL && I_PENABLE && I_PWRITE;
   assign apb_rd    = I_PSEL && !I_PWRITE;
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = 1'b0;

   assign kind_sel  = smcg_pkg::smcg_kind_t'(
                         core_ctrl_reg[`SMCG_KIND_HI:`SMCG_KIND_LO]);
   assign arm_ok    = core_ctrl_reg[`SMCG_ARM_BIT] && I_SLEEP_EXEC;
   // standby needs a crystal; otherwise kind 11 sleeps as power-down
   assign standby_ok = clk_src_reg[`SMCG_SRC_XTAL_BIT];

   // register writes
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         core_ctrl_reg <= `SMCG_CORE_CTRL_RST;
         clk_stop_reg  <= `SMCG_CLK_STOP_RST;
         clk_src_reg   <= `SMCG_CLK_SRC_RST;
      end else if (apb_wr) begin
         if (I_PADDR == `SMCG_ADDR_CORE_CTRL) begin
            core_ctrl_reg <= I_PWDATA[7:0] & `SMCG_CORE_CTRL_WMASK;
         end else if (I_PADDR == `SMCG_ADDR_CLK_STOP) begin
            clk_stop_reg <= I_PWDATA[3:0];
         end else if (I_PADDR == `SMCG_ADDR_CLK_SRC) begin
            clk_src_reg <= I_PWDATA[1:0];
         end
      end
   end

   // read mux, unmapped reads return zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (I_PADDR == `SMCG_ADDR_CORE_CTRL) begin
         rdata_next[7:0] = core_ctrl_reg;
      end else if (I_PADDR == `SMCG_ADDR_CLK_STOP) begin
         rdata_next[3:0] = clk_stop_reg;
      end else if (I_PADDR == `SMCG_ADDR_CLK_SRC) begin
         rdata_next[1:0] = clk_src_reg;
      end else if (I_PADDR == `SMCG_ADDR_STATUS) begin
         rdata_next[4:0] = state_reg;
         rdata_next[9:8] = kind_reg;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         O_PRDATA <= 32'h0000_0000;
      end else if (apb_rd && !I_PENABLE) begin
         O_PRDATA <= rdata_next;
      end
   end

   // wake qualification per sleep kind
   always_comb begin
      reset_hit = I_WAKE.ext_reset || I_WAKE.wdog_reset || I_WAKE.bod_reset;
      wake_hit  = 1'b0;
      case (kind_reg)
         smcg_pkg::SMCG_KIND_IDLE: begin
            // every interrupt source still clocked can wake
            wake_hit = I_IRQ_ENABLED && (I_WAKE.irq_zero_level || I_WAKE.irq_one_level
                       || I_WAKE.irq_zero_edge || I_WAKE.irq_one_edge
                       || I_WAKE.pin_change || I_WAKE.prog_ready || I_WAKE.conv_done
                       || I_WAKE.serial_irq || I_WAKE.wdog_irq
                       || I_WAKE.other_io_irq);
         end
         smcg_pkg::SMCG_KIND_NOISE: begin
            wake_hit = I_IRQ_ENABLED && (I_WAKE.conv_done || I_WAKE.prog_ready
                       || I_WAKE.irq_zero_level || I_WAKE.pin_change);
         end
         default: begin
            wake_hit = I_IRQ_ENABLED && (I_WAKE.irq_zero_level
                       || I_WAKE.pin_change);
         end
      endcase
   end

   // sleep sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
      case (state_reg)
         smcg_pkg::SMCG_ST_ACTIVE: begin
            if (arm_ok) begin
               state_next = smcg_pkg::SMCG_ST_SLEEP;
            end
         end
         smcg_pkg::SMCG_ST_SLEEP: begin
            if (reset_hit || wake_hit) begin
               state_next = smcg_pkg::SMCG_ST_STARTUP;
               if (kind_reg == smcg_pkg::SMCG_KIND_STANDBY) begin
                  cnt_next = CNT_W'(`SMCG_STANDBY_WAKE_CYC - 1);
               end else if (kind_reg == smcg_pkg::SMCG_KIND_PWRDOWN) begin
                  cnt_next = CNT_W'(STARTUP_CYC - 1);
               end else begin
                  cnt_next = '0;
               end
            end
         end
         smcg_pkg::SMCG_ST_STARTUP: begin
            if (cnt_reg == '0) begin
               state_next = smcg_pkg::SMCG_ST_RESTORE;
            end
         end
         smcg_pkg::SMCG_ST_RESTORE: begin
            // peripheral trees back before the cpu tree: one cycle on a reset wake, five on an interrupt wake
            state_next = smcg_pkg::SMCG_ST_HALT;
            cnt_next   = CNT_W'(`SMCG_IRQ_HALT_CYC - 1);
         end
         smcg_pkg::SMCG_ST_HALT: begin
            if (wake_by_reset_reg || cnt_reg == '0) begin
               state_next = smcg_pkg::SMCG_ST_ACTIVE;
            end
         end
         default: begin
            state_next = smcg_pkg::SMCG_ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         state_reg <= smcg_pkg::SMCG_ST_ACTIVE;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // latch kind and wake cause
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         kind_reg          <= smcg_pkg::SMCG_KIND_IDLE;
         wake_by_reset_reg <= 1'b0;
      end else if (state_reg == smcg_pkg::SMCG_ST_ACTIVE && arm_ok) begin
         if (kind_sel == smcg_pkg::SMCG_KIND_STANDBY && !standby_ok) begin
            kind_reg <= smcg_pkg::SMCG_KIND_PWRDOWN;
         end else begin
            kind_reg <= kind_sel;
         end
         wake_by_reset_reg <= 1'b0;
      end else if (state_reg == smcg_pkg::SMCG_ST_SLEEP && reset_hit) begin
         wake_by_reset_reg <= 1'b1;
      end
   end

   // clock domain enables per state and kind
   always_comb begin
      clk_en_next = '1;
      if (state_reg == smcg_pkg::SMCG_ST_SLEEP || state_reg == smcg_pkg::SMCG_ST_STARTUP) begin
         clk_en_next.cpu   = 1'b0;
         clk_en_next.flash = 1'b0;
         clk_en_next.pll   = clk_src_reg[`SMCG_SRC_PLL_BIT];
         case (kind_reg)
            smcg_pkg::SMCG_KIND_IDLE: begin
               clk_en_next.io = 1'b1;
            end
            smcg_pkg::SMCG_KIND_NOISE: begin
               clk_en_next.io   = 1'b0;
               clk_en_next.fast = 1'b0;
            end
            smcg_pkg::SMCG_KIND_PWRDOWN: begin
               clk_en_next.io   = 1'b0;
               clk_en_next.conv = 1'b0;
               clk_en_next.fast = 1'b0;
               clk_en_next.pll  = 1'b0;
               // oscillator restarts only for the start-up count
               clk_en_next.osc  = (state_reg == smcg_pkg::SMCG_ST_STARTUP);
            end
            default: begin
               clk_en_next.io   = 1'b0;
               clk_en_next.conv = 1'b0;
               clk_en_next.fast = 1'b0;
               clk_en_next.pll  = 1'b0;
            end
         endcase
      end else if (state_reg == smcg_pkg::SMCG_ST_RESTORE) begin
         clk_en_next.cpu   = 1'b0;
         clk_en_next.flash = 1'b0;
      end else if (state_reg == smcg_pkg::SMCG_ST_HALT && !wake_by_reset_reg) begin
         clk_en_next.cpu   = 1'b0;
         clk_en_next.flash = 1'b0;
      end
   end

   // gates change only at clock edges so the trees never see a runt pulse
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         O_CLK_EN <= '1;
      end else begin
         O_CLK_EN <= clk_en_next;
      end
   end

   // per-module stop; deep modes already gate the parent trees
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_mod
         always_ff @(posedge I_CLOCK) begin
            if (I_RST) begin
               O_MOD_CLK_EN[g]    <= 1'b1;
               O_MOD_ACCESS_OK[g] <= 1'b0;
            end else begin
               O_MOD_CLK_EN[g]    <= !clk_stop_reg[g];
               O_MOD_ACCESS_OK[g] <= I_MOD_ACCESS[g] && !clk_stop_reg[g];
            end
         end
      end
   endgenerate

   // one-cycle pulses for the core, plus the sleeping level
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         O_CONV_START   <= 1'b0;
         O_RESET_VECTOR <= 1'b0;
         O_IRQ_RESUME   <= 1'b0;
         O_SLEEPING     <= 1'b0;
      end else begin
         O_CONV_START   <= state_reg == smcg_pkg::SMCG_ST_ACTIVE && arm_ok && I_CONV_ENABLED
                           && !clk_stop_reg[`SMCG_STOP_CONVERTER]
                           && (kind_sel == smcg_pkg::SMCG_KIND_IDLE
                               || kind_sel == smcg_pkg::SMCG_KIND_NOISE);
         O_RESET_VECTOR <= state_reg == smcg_pkg::SMCG_ST_HALT && wake_by_reset_reg;
         O_IRQ_RESUME   <= state_reg == smcg_pkg::SMCG_ST_HALT && !wake_by_reset_reg
                           && cnt_reg == '0;
         O_SLEEPING     <= state_next != smcg_pkg::SMCG_ST_ACTIVE;
      end
   end

endmodule

// File: core/smcg_defines.svh
// offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SMCG_DEFINES_SVH
`define SMCG_DEFINES_SVH

`define SMCG_ADDR_CORE_CTRL     12'h000
`define SMCG_ADDR_CLK_STOP      12'h004
`define SMCG_ADDR_CLK_SRC       12'h008
`define SMCG_ADDR_STATUS        12'h00C

`define SMCG_ARM_BIT            5
`define SMCG_KIND_HI            4
`define SMCG_KIND_LO            3
`define SMCG_CORE_CTRL_RST      8'h00
`define SMCG_CORE_CTRL_WMASK    8'h38

`define SMCG_STOP_TIMER_ONE     3
`define SMCG_STOP_TIMER_ZERO    2
`define SMCG_STOP_SERIAL        1
`define SMCG_STOP_CONVERTER     0
`define SMCG_CLK_STOP_RST       4'h0

`define SMCG_SRC_PLL_BIT        0
`define SMCG_SRC_XTAL_BIT       1
`define SMCG_CLK_SRC_RST        2'h0

`define SMCG_STANDBY_WAKE_CYC   6
`define SMCG_IRQ_HALT_CYC       4
`define SMCG_DEF_STARTUP_CYC    16

`endif

// File: core/smcg_pkg.sv
// types shared by the sleep-mode clock-gating controller
package smcg_pkg;

   typedef enum logic [1:0] {
      SMCG_KIND_IDLE    = 2'h0,
      SMCG_KIND_NOISE   = 2'h1,
      SMCG_KIND_PWRDOWN = 2'h2,
      SMCG_KIND_STANDBY = 2'h3
   } smcg_kind_t;

   typedef enum logic [4:0] {
      SMCG_ST_ACTIVE  = 5'h01,
      SMCG_ST_SLEEP   = 5'h02,
      SMCG_ST_STARTUP = 5'h04,
      SMCG_ST_RESTORE = 5'h08,
      SMCG_ST_HALT    = 5'h10
   } smcg_state_t;

   // clock domain enables, one bit per gated tree
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic conv;
      logic fast;
      logic pll;
      logic osc;
   } smcg_clk_en_t;

   // wake sources presented by the rest of the core
   typedef struct packed {
      logic ext_reset;
      logic wdog_reset;
      logic bod_reset;
      logic irq_zero_level;
      logic irq_one_level;
      logic irq_zero_edge;
      logic irq_one_edge;
      logic pin_change;
      logic prog_ready;
      logic conv_done;
      logic serial_irq;
      logic wdog_irq;
      logic other_io_irq;
   } smcg_wake_t;

endpackage

// File: dv/smcg_sleep_ctrl_props.sv
// assertion checker for the sleep controller ports
`timescale 1ns/10ps
module smcg_sleep_ctrl_props (
   // clock, reset and apb
   input wire logic                   I_CLOCK,
   input wire logic                   I_RST,
   input wire logic                   I_PSEL,
   input wire logic                   I_PENABLE,
   input wire logic                   I_PWRITE,
   input wire logic [11:0]            I_PADDR,
   input wire logic [31:0]            I_PWDATA,
   input wire logic                   O_PREADY,
   input wire logic                   O_PSLVERR,
   // core side
   input wire logic                   I_SLEEP_EXEC,
   input wire logic                   I_CONV_ENABLED,
   input wire logic [3:0]             I_MOD_ACCESS,
   input wire smcg_pkg::smcg_clk_en_t O_CLK_EN,
   input wire logic [3:0]             O_MOD_CLK_EN,
   input wire logic [3:0]             O_MOD_ACCESS_OK,
   input wire logic                   O_CONV_START,
   input wire logic                   O_IRQ_RESUME,
   input wire logic                   O_SLEEPING
);
   logic [1:0] kind_q;
   logic       arm_q;
   logic       xtal_q;
   logic [3:0] stop_q;
   logic       go;
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   // shadow of the writable fields, updated at the apb access edge
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         {arm_q, kind_q, xtal_q, stop_q} <= 8'h00;
      end else if (I_PSEL && I_PENABLE && I_PWRITE) begin
         if (I_PADDR == 12'h000) {arm_q, kind_q} <= I_PWDATA[5:3];
         if (I_PADDR == 12'h004) stop_q <= I_PWDATA[3:0];
         if (I_PADDR == 12'h008) xtal_q <= I_PWDATA[1];
      end
   end
   assign go = !O_SLEEPING && O_CLK_EN.cpu && I_SLEEP_EXEC;
   a_apb_no_wait: assert property (O_PREADY && !O_PSLVERR)
      else $error("apb slave stalled or flagged an error");
   a_unarmed_stays: assert property (go && !arm_q |-> ##2 O_CLK_EN.cpu)
      else $error("sleep entered without arm bit");
   a_idle_gates: assert property (go && arm_q && kind_q == 2'h0
      |-> ##2 O_CLK_EN[6:2] == 5'h07)
      else $error("idle clock domains wrong");
   a_noise_gates: assert property (go && arm_q && kind_q == 2'h1
      |-> ##2 O_CLK_EN[6:2] == 5'h02)
      else $error("noise reduction clock domains wrong");
   a_deep_gates: assert property (go && arm_q && kind_q[1] |-> ##2
      (O_CLK_EN[6:1] == 6'h00 && O_CLK_EN.osc == (kind_q[0] && xtal_q)))
      else $error("deep sleep clock domains wrong");
   a_conv_kick: assert property (go && arm_q && !kind_q[1] && I_CONV_ENABLED
      && !stop_q[0] |=> O_CONV_START)
      else $error("conversion not started on sleep entry");
   a_no_conv_deep: assert property (go && arm_q && kind_q[1] |=> !O_CONV_START)
      else $error("conversion started in deep sleep");
   a_mod_clk_follow: assert property (O_MOD_CLK_EN == ~$past(stop_q))
      else $error("module clock enable does not follow stop bits");
   a_access_block: assert property ((O_MOD_ACCESS_OK & ~$past(I_MOD_ACCESS)) == 4'h0
      && (O_MOD_ACCESS_OK & $past(stop_q)) == 4'h0)
      else $error("stopped module register access granted");
   a_wake_order: assert property ($rose(O_CLK_EN.cpu) |->
      $past(O_CLK_EN.io && O_CLK_EN.conv) && O_CLK_EN.io && O_CLK_EN.conv)
      else $error("cpu clock released before peripheral clocks");
   a_resume_cpu: assert property (O_IRQ_RESUME |=> O_CLK_EN.cpu)
      else $error("cpu clock not running after resume");
endmodule
bind smcg_sleep_ctrl smcg_sleep_ctrl_props u_props (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
   .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
   .I_SLEEP_EXEC(I_SLEEP_EXEC), .I_CONV_ENABLED(I_CONV_ENABLED), .I_MOD_ACCESS(I_MOD_ACCESS),
   .O_CLK_EN(O_CLK_EN), .O_MOD_CLK_EN(O_MOD_CLK_EN), .O_MOD_ACCESS_OK(O_MOD_ACCESS_OK),
   .O_CONV_START(O_CONV_START), .O_IRQ_RESUME(O_IRQ_RESUME), .O_SLEEPING(O_SLEEPING));

// File: dv/smcg_sleep_ctrl_bench.sv
// self-checking bench for the sleep controller
`timescale 1ns/10ps
module smcg_sleep_ctrl_bench;
   localparam int STC = 2;
   logic                   clk, rst, psel, pen, pwr, slp, cven, irqen;
   logic                   pready, pslverr, cst, rvec, ires, slpg;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, rdata;
   logic [3:0]             macc, mclk, mok;
   smcg_pkg::smcg_wake_t   wake;
   smcg_pkg::smcg_clk_en_t clken;
   int                     n_errors, checks, cyc, n_conv;
   int                     lat [7];
   smcg_sleep_ctrl #(.STARTUP_CYC(STC)) DUT (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_SLEEP_EXEC(slp), .I_CONV_ENABLED(cven),
      .I_WAKE(wake), .I_IRQ_ENABLED(irqen), .I_MOD_ACCESS(macc), .O_CLK_EN(clken),
      .O_MOD_CLK_EN(mclk), .O_MOD_ACCESS_OK(mok), .O_CONV_START(cst), .O_RESET_VECTOR(rvec),
      .O_IRQ_RESUME(ires), .O_SLEEPING(slpg));
   task automatic tally_and_finish;
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; an idle edge after release keeps strobes from re-rising at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_regs;
      apb(0, 12'h000, 32'h0);
      chk("ctrl_rst", rdata, 32'h0);
      apb(0, 12'h00C, 32'h0);
      chk("status", rdata, 32'h1);
      apb(1, 12'h000, 32'hFFFFFFFF);
      apb(0, 12'h000, 32'h0);
      chk("ctrl_bits", rdata, 32'h38);
      apb(1, 12'h000, 32'h0);
      cven <= 1'b0;
      apb(1, 12'h004, 32'hFFFFFFFF);
      apb(0, 12'h004, 32'h0);
      chk("stop_bits", rdata, 32'hF);
      chk("stop_gate", {mclk, mok}, 8'h00);
      apb(1, 12'h004, 32'h5);
      // module enables follow one edge after the write lands
      @(posedge clk);
      chk("part_gate", {mclk, mok}, 8'hAA);
      macc <= 4'h6;
      repeat (2) @(posedge clk);
      chk("acc_req", mok, 4'h2);
      macc <= 4'hF;
      apb(1, 12'h004, 32'h0);
      @(posedge clk);
      chk("restart", {mclk, mok}, 8'hFF);
      cven <= 1'b1;
      apb(0, 12'h010, 32'h0);
      chk("unmapped", rdata, 32'h0);
   endtask
   task automatic t_unarmed;
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      repeat (4) @(posedge clk);
      chk("unarmed", {clken, slpg}, {7'h7F, 1'b0});
   endtask
   // enter one sleep kind, offer refused wake sources, then wake for real
   task automatic nap(input int i, input logic [1:0] k, input logic [1:0] src,
                      input logic [6:0] en, input logic [12:0] junk, input logic [12:0] wk);
      int c0;
      int n;
      c0 = n_conv;
      apb(1, 12'h008, {30'h0, src});
      apb(1, 12'h000, {26'h0, 1'b1, k, 3'h0});
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      repeat (3) @(posedge clk);
      chk("gated", clken, en);
      wake <= junk;
      repeat (20) @(posedge clk);
      chk("asleep", {clken, slpg}, {en, 1'b1});
      wake <= wk;
      for (n = 0; n < 200 && ires !== 1'b1 && rvec !== 1'b1; n++) @(posedge clk);
      lat[i] = n;
      chk("wake_kind", {ires, rvec}, {~wk[12], wk[12]});
      wake <= '0;
      repeat (3) @(posedge clk);
      chk("restored", {clken, slpg}, {7'h7F, 1'b0});
      chk("conv_start", n_conv - c0, {31'h0, ~k[1]});
      apb(1, 12'h000, 32'h0);
   endtask
   // interrupts masked in idle: only a reset source may end the sleep
   task automatic t_masked;
      int n;
      irqen <= 1'b0;
      apb(1, 12'h000, 32'h20);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      wake <= 13'h03FF;
      repeat (20) @(posedge clk);
      chk("masked", {clken, slpg}, {7'h1F, 1'b1});
      wake <= 13'h0800;
      for (n = 0; n < 200 && rvec !== 1'b1; n++) @(posedge clk);
      chk("masked_rst", {ires, rvec}, 2'h1);
      wake <= '0;
      irqen <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1, 12'h000, 32'h0);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      n_conv += (cst === 1'b1);
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   initial begin
      {rst, psel, pen, pwr, slp, cven, irqen} = 7'h43;
      {paddr, pwdata, macc, wake} = '0;
      macc = 4'hF;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_unarmed;
      nap(0, 2'h0, 2'h3, 7'h1F, 13'h0000, 13'h0001);
      nap(1, 2'h1, 2'h3, 7'h0B, 13'h00C1, 13'h0008);
      nap(2, 2'h2, 2'h3, 7'h00, 13'h00CD, 13'h0020);
      nap(3, 2'h3, 2'h3, 7'h01, 13'h00CD, 13'h0200);
      nap(4, 2'h3, 2'h1, 7'h00, 13'h0000, 13'h0200);
      nap(5, 2'h0, 2'h0, 7'h1D, 13'h0000, 13'h0200);
      nap(6, 2'h2, 2'h3, 7'h00, 13'h0000, 13'h1000);
      t_masked;
      chk("standby_lat", lat[3] - lat[0], 32'd5);
      chk("pdown_lat", lat[2] - lat[0], STC - 1);
      chk("noxtal_lat", lat[4], lat[2]);
      chk("halt_lat", lat[2] - lat[6], 32'd3);
      tally_and_finish;
   end
endmodule
